// *** hw/tcx_pkg.sv ***
/*
  Constants shared by the sixteen-bit timer/counter: register offsets,
  field positions, reset values and fixed counts.
  Assumes a 32-bit Avalon-MM slave port with byte addressing.
*/
package tcx_pkg;
  // ==========================================================
  // Register byte offsets
  localparam int TCX_ADDR_W = 5;
  localparam logic [4:0] TCX_ADR_CNT_LO = 5'h00;
  localparam logic [4:0] TCX_ADR_CNT_HI = 5'h04;
  localparam logic [4:0] TCX_ADR_CTRL = 5'h08;
  localparam logic [4:0] TCX_ADR_GATE = 5'h0C;
  localparam logic [4:0] TCX_ADR_STAT = 5'h10;
  localparam logic [4:0] TCX_ADR_MASK = 5'h14;

  // ==========================================================
  // Field positions in the control, gate and status registers
  localparam int TCX_CTL_RUN = 0;
  localparam int TCX_CTL_SYNC_N = 2;
  localparam int TCX_CTL_OSC_EN = 3;
  localparam int TCX_CTL_PS_LO = 4;
  localparam int TCX_CTL_CS_LO = 6;
  localparam int TCX_GATE_EN = 7;
  localparam int TCX_STAT_OVF = 0;

  // ==========================================================
  // Source select codes
  localparam logic [1:0] TCX_CS_INST = 2'h0;
  localparam logic [1:0] TCX_CS_SYS = 2'h1;
  localparam logic [1:0] TCX_CS_EXT = 2'h2;
  localparam logic [1:0] TCX_CS_CAP = 2'h3;

  // ==========================================================
  // Reset values and counts
  localparam logic [15:0] TCX_CNT_RST = 16'h0000;
  localparam logic [15:0] TCX_CNT_MAX = 16'hFFFF;
  localparam logic [7:0] TCX_CTRL_RST = 8'h00;
  localparam logic [1:0] TCX_INST_LAST = 2'h3;
  localparam logic [2:0] TCX_PRE_RST = 3'h0;
endpackage

// *** hw/tcx_edge_sync.sv ***
/*
  Edge detector for the external count source, with an optional
  two-stage synchronizer that can be bypassed.
  Assumes the raw input is sampled on ref_clk_i.
*/
`timescale 1ns/10ps
module tcx_edge_sync (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Source and mode
  input wire logic raw_i,
  input wire logic bypass_i,
  // Edge pulses
  output logic rise_o,
  output logic fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } tcx_es_state_t;

  tcx_es_state_t st_r;
  tcx_es_state_t st_nxt;
  logic sel;

  // ==========================================================
  // Path select; first stage feeds only the second stage
  assign sel = bypass_i ? raw_i : st_r.s2;
  assign rise_o = sel & ~st_r.prev;
  assign fall_o = ~sel & st_r.prev;

  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = raw_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.prev = sel;
  end

  // State register, frozen while ce_i is low
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end
endmodule

// *** hw/tcx_timer.sv ***
/*
  Sixteen-bit timer/counter with source select, 1/2/4/8 prescaler,
  run/gate enable, optional synchronizer and overflow interrupt.
  Assumes an Avalon-MM master on ref_clk_i and gate_i from gate logic.
*/
`timescale 1ns/10ps
// Functional notes
// - 16-bit up-counter, byte writes replace live count
// - Run off stops; gate enable needs gate
// - Source select picks sys, inst, cap, pin/xtal
// - Instruction source advances once per instruction cycle
// - System clock source advances four per instruction
// - External source counts rising edges, sync or async
// - First rising edge waits for a falling edge
// - Prescaler divides 1/2/4/8, not software visible
// - Count byte write clears the prescaler
// - Oscillator enable starts crystal driver, runs asleep
// - Sync disable bypasses the synchronizer
// - Async external counting continues and wakes in sleep
// - Mode switch may lose or add one increment
// - Wrap from maximum sets the overflow flag
// - Count byte reads are always valid
module tcx_timer (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Avalon-MM slave
  input wire logic [tcx_pkg::TCX_ADDR_W-1:0] avm_address_i,
  input wire logic avm_read_i,
  input wire logic avm_write_i,
  input wire logic [31:0] avm_writedata_i,
  input wire logic [3:0] avm_byteenable_i,
  output logic [31:0] avm_readdata_o,
  output logic avm_waitrequest_o,
  // Count sources and system state
  input wire logic ext_count_pin_i,
  input wire logic cap_osc_i,
  input wire logic xtal_in_pin_i,
  input wire logic gate_i,
  input wire logic sleep_i,
  // Crystal driver and interrupt
  output logic xtal_out_pin_o,
  output logic irq_o
);
  import tcx_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic [2:0] pre;
    logic [1:0] phase;
    logic [7:0] ctrl;
    logic gate_en;
    logic armed;
    logic ovf;
    logic ovf_mask;
    logic ack;
    logic wait_n;
    logic [7:0] rdata;
    logic irq;
    logic xo;
  } tcx_state_t;

  tcx_state_t st_r;
  tcx_state_t st_nxt;

  logic run;
  logic sync_n;
  logic osc_en;
  logic [1:0] ps;
  logic [1:0] cs;
  logic ext_mode;
  logic raw_src;
  logic rise;
  logic fall;
  logic take;
  logic do_wr;
  logic wr_lo;
  logic wr_hi;
  logic cnt_wr;
  logic tick;
  logic count_en;
  logic inc;

  // ==========================================================
  // Helpers
  // Last prescaler state for a code: power of two minus one
  function automatic logic [2:0] pre_last(input logic [1:0] code);
    unique case (code)
      2'h0: pre_last = 3'h0;
      2'h1: pre_last = 3'h1;
      2'h2: pre_last = 3'h3;
      2'h3: pre_last = 3'h7;
    endcase
  endfunction

  // Register read mux; unmapped addresses read zero
  function automatic logic [7:0] reg_read(input logic [4:0] adr, input tcx_state_t s);
    reg_read = 8'h00;
    unique case (adr)
      TCX_ADR_CNT_LO: reg_read = s.count[7:0];
      TCX_ADR_CNT_HI: reg_read = s.count[15:8];
      TCX_ADR_CTRL: reg_read = s.ctrl;
      TCX_ADR_GATE: reg_read = {s.gate_en, 7'h00};
      TCX_ADR_STAT: reg_read = {7'h00, s.ovf};
      TCX_ADR_MASK: reg_read = {7'h00, s.ovf_mask};
      default: reg_read = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // Control field decode
  assign run = st_r.ctrl[TCX_CTL_RUN];
  assign sync_n = st_r.ctrl[TCX_CTL_SYNC_N];
  assign osc_en = st_r.ctrl[TCX_CTL_OSC_EN];
  assign ps = st_r.ctrl[TCX_CTL_PS_LO +: 2];
  assign cs = st_r.ctrl[TCX_CTL_CS_LO +: 2];
  assign ext_mode = (cs == TCX_CS_EXT) || (cs == TCX_CS_CAP);

  assign raw_src = (cs == TCX_CS_CAP) ? cap_osc_i : (osc_en ? xtal_in_pin_i : ext_count_pin_i);

  // bypass when sync disable set; two-stage path otherwise
  tcx_edge_sync u_edge (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .raw_i(raw_src),
    .bypass_i(sync_n),
    .rise_o(rise),
    .fall_o(fall)
  );

  // ==========================================================
  // Bus handshake: accept, then one cycle with waitrequest low
  assign take = (avm_read_i | avm_write_i) & ~st_r.ack;
  assign do_wr = st_r.ack & avm_write_i & avm_byteenable_i[0];
  assign wr_lo = do_wr && (avm_address_i == TCX_ADR_CNT_LO);
  assign wr_hi = do_wr && (avm_address_i == TCX_ADR_CNT_HI);
  assign cnt_wr = wr_lo | wr_hi;

  // ==========================================================
  // Count tick selection and enable
  always_comb begin
    tick = 1'b0;
    unique case (cs)
      // every system clock, four per instruction
      TCX_CS_SYS: tick = ~sleep_i;
      TCX_CS_INST: tick = ~sleep_i && (st_r.phase == TCX_INST_LAST);
      // rising edge of pin, crystal or cap oscillator
      // only once a falling edge armed it
      // async path keeps counting asleep; sync path stops
      TCX_CS_EXT, TCX_CS_CAP: tick = rise & st_r.armed & ~(sleep_i & ~sync_n);
    endcase
  end

  assign count_en = run & (~st_r.gate_en | gate_i) & tick;
  // prescaler terminal state advances the count
  assign inc = count_en && (st_r.pre >= pre_last(ps));

  // ==========================================================
  // Next state; mode switches need no special handling
  always_comb begin
    st_nxt = st_r;
    st_nxt.phase = st_r.phase + 2'h1;
    if (inc) begin
      st_nxt.count = st_r.count + 16'h0001;
    end
    if (wr_lo) begin
      st_nxt.count[7:0] = avm_writedata_i[7:0];
    end
    if (wr_hi) begin
      st_nxt.count[15:8] = avm_writedata_i[7:0];
    end
    if (cnt_wr || inc) begin
      st_nxt.pre = TCX_PRE_RST;
    end else if (count_en) begin
      st_nxt.pre = st_r.pre + 3'h1;
    end
    // disarm on write or stop, arm on falling edge
    if (cnt_wr || !run || !ext_mode) begin
      st_nxt.armed = 1'b0;
    end else if (fall) begin
      st_nxt.armed = 1'b1;
    end
    // Control, gate and mask registers
    if (do_wr && avm_address_i == TCX_ADR_CTRL) begin
      st_nxt.ctrl = avm_writedata_i[7:0];
    end
    if (do_wr && avm_address_i == TCX_ADR_GATE) begin
      st_nxt.gate_en = avm_writedata_i[TCX_GATE_EN];
    end
    if (do_wr && avm_address_i == TCX_ADR_MASK) begin
      st_nxt.ovf_mask = avm_writedata_i[TCX_STAT_OVF];
    end
    // wrap sets flag; set wins over write-one-to-clear
    if (inc && st_r.count == TCX_CNT_MAX) begin
      st_nxt.ovf = 1'b1;
    end else if (do_wr && avm_address_i == TCX_ADR_STAT && avm_writedata_i[TCX_STAT_OVF]) begin
      st_nxt.ovf = 1'b0;
    end
    // level interrupt doubles as the wake request
    st_nxt.irq = st_nxt.ovf & st_nxt.ovf_mask;
    // crystal amplifier runs whenever enabled, asleep or not
    st_nxt.xo = osc_en & ~xtal_in_pin_i;
    // Bus answer; read data latched at acceptance
    st_nxt.ack = take;
    st_nxt.wait_n = take;
    if (take) begin
      st_nxt.rdata = reg_read(avm_address_i, st_r);
    end
  end

  // State register, frozen while ce_i is low
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs straight from flops
  assign avm_readdata_o = {24'h000000, st_r.rdata};
  assign avm_waitrequest_o = ~st_r.wait_n;
  assign irq_o = st_r.irq;
  assign xtal_out_pin_o = st_r.xo;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  chk_write_low_byte: assert property (
    ce_i && wr_lo |=> st_r.count[7:0] == $past(avm_writedata_i[7:0]))
    else $error("low byte write not applied");
  chk_off_holds: assert property (
    !run && !cnt_wr |=> $stable(st_r.count))
    else $error("count moved while run bit off");
  chk_sys_rate: assert property (
    ce_i && run && (!st_r.gate_en || gate_i) && cs == TCX_CS_SYS && ps == 2'h0 && !sleep_i
    && !cnt_wr
    |=> st_r.count == 16'($past(st_r.count) + 16'h0001))
    else $error("system clock source did not count each cycle");
  chk_inst_rate: assert property (
    cs == TCX_CS_INST && st_r.phase != TCX_INST_LAST && !cnt_wr |=> $stable(st_r.count))
    else $error("instruction source counted off its phase");
  chk_prescale_clear: assert property (
    ce_i && cnt_wr |=> st_r.pre == TCX_PRE_RST)
    else $error("prescaler not cleared by count write");
  chk_first_edge: assert property (
    ce_i && cnt_wr |=> !st_r.armed ##0 !inc)
    else $error("counter armed right after a count write");
  chk_ovf_set: assert property (
    ce_i && inc && st_r.count == TCX_CNT_MAX && !cnt_wr |=> st_r.ovf && st_r.count == 16'h0000)
    else $error("wrap did not set overflow");
  chk_sleep_sync: assert property (
    sleep_i && !sync_n && !cnt_wr |-> !inc)
    else $error("synchronous path counted during sleep");
  chk_irq_level: assert property (
    ce_i && st_r.ovf && st_r.ovf_mask && !do_wr |=> irq_o)
    else $error("unmasked overflow did not raise interrupt");
  chk_xtal_off: assert property (
    ce_i && !osc_en |=> !xtal_out_pin_o)
    else $error("crystal driver active while disabled");
  chk_bus_answer: assert property (
    ce_i && take |=> !avm_waitrequest_o ##1 (avm_waitrequest_o || !ce_i))
    else $error("bus answer not one cycle");

  // ==========================================================
  // Further guards: arming, flag clear, sleep and clock enable
  // An unarmed detector may only arm through a falling edge
  chk_arm_needs_fall: assert property (
    !st_r.armed && !fall |=> !st_r.armed)
    else $error("counter armed without a falling edge");
  // Write-one clears the flag unless a wrap lands in the same cycle
  chk_flag_clear: assert property (
    ce_i && do_wr && avm_address_i == TCX_ADR_STAT && avm_writedata_i[TCX_STAT_OVF] && !inc
    |=> !st_r.ovf)
    else $error("overflow flag not cleared by write one");
  // Asynchronous external counting must survive sleep
  chk_async_sleep: assert property (
    ce_i && sleep_i && sync_n && run && (!st_r.gate_en || gate_i) && ext_mode && ps == 2'h0
    && rise && st_r.armed && !cnt_wr |=> st_r.count == 16'($past(st_r.count) + 16'h0001))
    else $error("asynchronous count stopped during sleep");
  // Low enable must hold every state bit, bus handshake included
  chk_ce_freeze: assert property (
    !ce_i |=> $stable(st_r))
    else $error("state changed while clock enable low");

  cov_overflow: cover property (inc && st_r.count == TCX_CNT_MAX);
  cov_ext_count: cover property (inc && ext_mode);
  cov_async_sleep: cover property (inc && sleep_i && sync_n);
  cov_div8: cover property (inc && ps == 2'h3);
  cov_ce_freeze: cover property (!ce_i && run);
endmodule

// *** verification/tcx_src_model.sv ***
/*
  Far-side model: count pin, capacitive oscillator and a crystal.
  Assumes it is clocked by the bench clock; pins change after edges.
*/
`timescale 1ns/10ps
module tcx_src_model (
  // Clock and crystal drive
  input wire logic ref_clk_i,
  input wire logic xtal_out_pin_i,
  // Count sources
  output logic ext_count_pin_o,
  output logic cap_osc_o,
  output logic xtal_in_pin_o
);
  logic [3:0] dly_r;

  // ==========================================
  // Crystal
  // crystal runs when driven
  // Loop delay sets the swing period; an undriven crystal stops low
  initial begin
    ext_count_pin_o = 1'b0;
    cap_osc_o = 1'b0;
  end
  always @(posedge ref_clk_i) begin
    dly_r <= {dly_r[2:0], xtal_out_pin_i};
    xtal_in_pin_o <= dly_r[3];
  end

  // ==========================================
  // Pin drivers
  task automatic level(input logic sel, input logic lvl);
    @(posedge ref_clk_i);
    if (sel) begin
      cap_osc_o <= lvl;
    end else begin
      ext_count_pin_o <= lvl;
    end
  endtask

  // Slow pulses, four cycles per phase, so the synchronizer keeps up
  task automatic burst(input int n, input logic sel);
    repeat (n) begin
      level(sel, 1'b0);
      repeat (3) @(posedge ref_clk_i);
      level(sel, 1'b1);
      repeat (3) @(posedge ref_clk_i);
    end
  endtask
endmodule

// *** verification/tb_top.sv ***
/*
  Self-checking bench: bus tasks, read scoreboard, gated, external
  and overflow scenarios.
  Assumes tcx_src_model drives the count sources and the crystal.
*/
`timescale 1ns/10ps
module tb_top;
  import tcx_pkg::*;
  logic clk, nrst, ce, rd, wr, gate, slp, ext, cap, xin, xout, irq, wreq;
  logic [4:0] adr;
  logic [31:0] wd, rdata;
  logic [3:0] be;
  logic [31:0] q[$];
  int miscompares = 0;
  int total_checks = 0;

  tcx_timer i_tcx_timer (
    .ref_clk_i(clk), .nrst_i(nrst), .ce_i(ce),
    .avm_address_i(adr), .avm_read_i(rd), .avm_write_i(wr),
    .avm_writedata_i(wd), .avm_byteenable_i(be),
    .avm_readdata_o(rdata), .avm_waitrequest_o(wreq),
    .ext_count_pin_i(ext), .cap_osc_i(cap), .xtal_in_pin_i(xin),
    .gate_i(gate), .sleep_i(slp), .xtal_out_pin_o(xout), .irq_o(irq)
  );
  tcx_src_model i_tcx_src_model (
    .ref_clk_i(clk), .xtal_out_pin_i(xout),
    .ext_count_pin_o(ext), .cap_osc_o(cap), .xtal_in_pin_o(xin)
  );

  // ==========================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    results();
  end

  // ==========================================
  // Checking
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Read data is taken at the edge that samples waitrequest low
  always @(posedge clk) begin
    if (rd === 1'b1 && wreq === 1'b0 && q.size() > 0) begin
      chk(rdata, q.pop_front());
    end
  end

  // ==========================================
  // Bus master: hold everything until waitrequest is seen low
  task automatic bus(input logic r, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge clk);
    rd <= r;
    wr <= !r;
    adr <= a;
    wd <= d;
    be <= b;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wrx(input logic [4:0] a, input logic [31:0] d);
    bus(1'b0, a, d, 4'h1);
  endtask
  task automatic rdx(input logic [4:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b1, a, 32'h0000_0000, 4'hF);
  endtask
  task automatic rd_cnt(input logic [15:0] e);
    rdx(TCX_ADR_CNT_LO, {24'h000000, e[7:0]});
    rdx(TCX_ADR_CNT_HI, {24'h000000, e[15:8]});
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] cs, input logic [1:0] ps,
                                      input logic osc, input logic syncn, input logic run);
    return {24'h000000, cs, ps, osc, syncn, 1'b0, run};
  endfunction

  // Gate open for n sampled edges; clock enable low for the last f of them
  task automatic gate_win(input int n, input int f);
    @(posedge clk);
    gate <= 1'b1;
    repeat (n - f) @(posedge clk);
    ce <= 1'b0;
    repeat (f) @(posedge clk);
    ce <= 1'b1;
    gate <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // Count writes disarm the edge detector and clear the prescaler
  task automatic ext_case(input logic [31:0] c, input logic sel, input logic lvl,
                          input int n, input logic [15:0] e);
    i_tcx_src_model.level(sel, lvl);
    wrx(TCX_ADR_CTRL, c);
    wrx(TCX_ADR_CNT_LO, 32'h0000_0000);
    i_tcx_src_model.burst(n, sel);
    repeat (8) @(posedge clk);
    rd_cnt(e);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    int v;
    int n;
    {nrst, rd, wr, gate, slp, adr, wd, be} = '0;
    ce = 1'b1;
    v = $urandom(10);
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    // Reset values, unmapped place, write with byte lane off
    rdx(TCX_ADR_STAT, 32'h0000_0000);
    rdx(5'h18, 32'h0000_0000);
    bus(1'b0, TCX_ADR_CTRL, 32'h0000_00FF, 4'h0);
    rdx(TCX_ADR_CTRL, 32'h0000_0000);
    repeat (4) begin
      v = $urandom;
      wrx(TCX_ADR_CNT_LO, {24'h000000, v[7:0]});
      wrx(TCX_ADR_CNT_HI, {24'h000000, v[15:8]});
      rd_cnt(v[15:0]);
    end
    // Gated internal sources: system, instruction, run off, asleep
    wrx(TCX_ADR_GATE, 32'h0000_0080);
    for (int i = 0; i < 4; i++) begin
      wrx(TCX_ADR_CNT_LO, 32'h0000_0000);
      wrx(TCX_ADR_CNT_HI, 32'h0000_0000);
      wrx(TCX_ADR_CTRL, ctl(i == 1 ? TCX_CS_INST : TCX_CS_SYS, 2'h0, 1'b0, 1'b0, i != 2));
      slp <= (i == 3);
      gate_win(40, 8);
      slp <= 1'b0;
      rd_cnt(i == 0 ? 16'h0020 : (i == 1 ? 16'h0008 : 16'h0000));
    end
    // External pin and capacitive source, prescaler, sleep
    wrx(TCX_ADR_GATE, 32'h0000_0000);
    n = 2 + int'($urandom % 10);
    ext_case(ctl(TCX_CS_EXT, 2'h0, 1'b0, 1'b1, 1'b1), 1'b0, 1'b1, n, 16'(n));
    ext_case(ctl(TCX_CS_EXT, 2'h0, 1'b0, 1'b1, 1'b1), 1'b0, 1'b0, n, 16'(n - 1));
    ext_case(ctl(TCX_CS_EXT, 2'h0, 1'b0, 1'b0, 1'b1), 1'b0, 1'b1, n, 16'(n));
    ext_case(ctl(TCX_CS_CAP, 2'h0, 1'b0, 1'b1, 1'b1), 1'b1, 1'b1, n, 16'(n));
    for (int p = 1; p < 4; p++) begin
      ext_case(ctl(TCX_CS_EXT, 2'(p), 1'b0, 1'b1, 1'b1), 1'b0, 1'b1, 16, 16'(16 >> p));
    end
    repeat (2) ext_case(ctl(TCX_CS_EXT, 2'h2, 1'b0, 1'b1, 1'b1), 1'b0, 1'b1, 3, 16'h0000);
    slp <= 1'b1;
    ext_case(ctl(TCX_CS_EXT, 2'h0, 1'b0, 1'b1, 1'b1), 1'b0, 1'b1, n, 16'(n));
    slp <= 1'b0;
    // Overflow sets status, mask gates the interrupt, write one clears
    wrx(TCX_ADR_CNT_HI, 32'h0000_00FF);
    wrx(TCX_ADR_CNT_LO, 32'h0000_00FF);
    wrx(TCX_ADR_MASK, 32'h0000_0001);
    i_tcx_src_model.burst(1, 1'b0);
    repeat (8) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    rd_cnt(16'h0000);
    rdx(TCX_ADR_STAT, 32'h0000_0001);
    wrx(TCX_ADR_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    wrx(TCX_ADR_STAT, 32'h0000_0001);
    rdx(TCX_ADR_STAT, 32'h0000_0000);
    // oscillator first, start-up wait, then run
    wrx(TCX_ADR_CTRL, ctl(TCX_CS_EXT, 2'h0, 1'b1, 1'b1, 1'b0));
    repeat (100) @(posedge clk);
    wrx(TCX_ADR_CTRL, ctl(TCX_CS_EXT, 2'h0, 1'b1, 1'b1, 1'b1));
    v = 0;
    repeat (64) begin
      @(posedge clk);
      v += int'(xout === 1'b1);
    end
    chk({31'h0, v > 0 && v < 64}, 32'h0000_0001);
    wrx(TCX_ADR_CTRL, 32'h0000_0000);
    repeat (4) @(posedge clk);
    chk({31'h0, xout}, 32'h0000_0000);
    repeat (4) @(posedge clk);
    results();
  end
endmodule
